/* File: design/atss_pkg.sv */
// constants, register map and types for the absolute time source block
package atss_pkg;
   localparam int unsigned clk_mhz = 100;
   localparam int unsigned one_sec_us = 1000000;
   localparam logic [19:0] us_max = 20'hF_423F;
   localparam logic [6:0] us_div = 7'h64;
   localparam logic [26:0] int_tick_cycles = 27'h5F5_E100;
   localparam logic [11:0] addr_ctrl = 12'h000;
   localparam logic [11:0] addr_port = 12'h004;
   localparam logic [11:0] addr_ptp0 = 12'h008;
   localparam logic [11:0] addr_ptp1 = 12'h00C;
   localparam logic [11:0] addr_stat = 12'h010;
   localparam logic [11:0] addr_dt = 12'h014;
   localparam logic [11:0] addr_us = 12'h018;
   localparam logic [11:0] addr_offs = 12'h01C;
   localparam logic [11:0] addr_nmea = 12'h020;
   localparam logic [15:0] port_reset = 16'h277E;
   localparam logic [31:0] ns_per_us = 32'h0000_03E8;
   localparam logic [6:0] limit_reset = 7'h01;
   localparam logic [6:0] limit_min = 7'h01;
   localparam logic [6:0] limit_max = 7'h64;
   localparam logic [6:0] domain_max = 7'h7F;
   localparam logic signed [3:0] ann_reset = 4'sh1;
   localparam logic signed [3:0] ann_min = -4'sh2;
   localparam logic signed [3:0] int_max = 4'sh3;
   localparam logic signed [3:0] sync_reset = 4'sh1;
   localparam logic signed [3:0] dreq_reset = 4'sh0;
   localparam logic signed [3:0] sync_min = -4'sh7;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
   typedef enum logic {atss_src_gnss, atss_src_ptp} atss_src_t;
   typedef enum logic {atss_nmea_rmc, atss_nmea_gga} atss_nmea_t;
   typedef enum logic [1:0] {atss_prof_1588, atss_prof_8021as, atss_prof_auto}
      atss_prof_t;
   typedef enum logic {atss_tr_udp, atss_tr_l2} atss_tr_t;
endpackage

/* File: design/atss_us_counter.sv */
// microsecond field below one second with alignment and full-second strobe
module atss_us_counter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic align,
   output logic [19:0] us,
   output logic wrap
);
   logic [6:0] div;
   logic [6:0] next_div;
   logic [19:0] next_us;
   logic tick;

   always_comb begin
      tick = (div == atss_pkg::us_div - 7'h01);
      next_div = tick ? 7'h00 : div + 7'h01;
      next_us = us;
      wrap = tick && (us == atss_pkg::us_max);
      if (tick) begin
         next_us = wrap ? 20'h0_0000 : us + 20'h0_0001;
      end
      if (align) begin
         next_div = 7'h00;
         next_us = 20'h0_0000;
      end
      if (!aresetn) begin
         next_div = 7'h00;
         next_us = 20'h0_0000;
      end
   end

   always_ff @(posedge aclk) begin
      div <= next_div;
      us <= next_us;
   end
endmodule // atss_us_counter

/* File: design/atss_time_core.sv */
// absolute time source selection, system time keeping and setting registers

// Notes on behaviour
// - time from gnss (default) or ptp master
// - both locked: load date, align microseconds
// - sentence only: load date if pps unrequired
// - pps only: align us; none: nothing
// - seconds value plus separate microsecond field
// - gnss packet port, default 10110
// - ptp source stops gnss packets
// - profiles; udp transport only with 1588v2
// - domain 0 to 127, default 0
// - announce exponent -2..3, default 1
// - sync exponent -7..3, default 1
// - delay request exponent -7..3, default 0
// - gnss locked: full second at pps rise
// - nothing locked: internal 1 hz second
module atss_time_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pps_in,
   input wire logic nmea_lock_in,
   input wire logic pps_lock_in,
   input wire logic nmea_valid,
   input wire logic [31:0] nmea_seconds,
   input wire logic ptp_offset_valid,
   input wire logic [31:0] ptp_offset_ns,
   input wire logic ptp_second,
   output logic [31:0] date_time,
   output logic [19:0] us_stamp,
   output logic full_second,
   output logic ptp_locked,
   output logic gnss_pkt_en,
   output logic [15:0] gnss_port
);
   // synchronisers for pins from outside the clock domain
   logic [1:0] pps_s1, pps_s2, nl_s1, nl_s2, pl_s1;
   logic pps_q, pps_rise, nmea_lk, pps_lk;
   logic pl_s2;
   always_ff @(posedge aclk) begin
      pps_s1 <= {pps_s1[0], pps_in};
      nl_s1 <= {nl_s1[0], nmea_lock_in};
      pl_s1 <= {pl_s1[0], pps_lock_in};
      pps_q <= pps_s1[1];
   end
   assign pps_s2 = pps_s1;
   assign nl_s2 = nl_s1;
   assign pl_s2 = pl_s1[1];
   assign nmea_lk = nl_s2[1];
   assign pps_lk = pl_s2;
   assign pps_rise = pps_s1[1] && !pps_q;

   // settings
   atss_pkg::atss_src_t src, next_src;
   atss_pkg::atss_nmea_t nmode, next_nmode;
   atss_pkg::atss_prof_t prof, next_prof;
   atss_pkg::atss_tr_t tr, next_tr;
   logic req_pps, next_req_pps;
   logic [15:0] next_port;
   logic [6:0] limit, next_limit, domain, next_domain;
   logic signed [3:0] ann, next_ann, syn, next_syn, dreq, next_dreq;
   logic [31:0] next_dt;
   logic [31:0] offs_abs, next_offs_abs;
   logic next_ptp_locked;
   logic [26:0] tick_cnt, next_tick_cnt;
   logic int_tick;
   logic align;
   logic us_wrap;
   logic [31:0] lim_ns;

   // axi state
   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [11:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata, rd_word, wr_word;
   logic wr_go, wr_ok, rd_ok;

   // saturate a signed exponent into its legal range
   function automatic logic signed [3:0] clampi(input logic signed [3:0] v,
         input logic signed [3:0] lo, input logic signed [3:0] hi);
      clampi = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   atss_us_counter u_us (
      .aclk(aclk),
      .aresetn(aresetn),
      .align(align),
      .us(us_stamp),
      .wrap(us_wrap)
   );

   always_comb begin
      s_axi_awready = !aw_full && !s_axi_bvalid;
      s_axi_wready = !w_full && !s_axi_bvalid;
      s_axi_arready = !s_axi_rvalid;
      wr_go = aw_full && w_full && !s_axi_bvalid;
      // lock window in ns from the microsecond limit
      lim_ns = 32'(limit) * atss_pkg::ns_per_us;
      // byte lanes without a strobe arrive as zero
      wr_word = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         if (s_axi_wstrb[i]) begin
            wr_word[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
         end
      end
      case (s_axi_araddr)
         atss_pkg::addr_ctrl: rd_word = {26'h000_0000, tr, prof, nmode, req_pps, src};
         atss_pkg::addr_port: rd_word = {16'h0, gnss_port};
         atss_pkg::addr_ptp0: rd_word = {9'h0, domain, 9'h0, limit};
         atss_pkg::addr_ptp1: rd_word = {20'h0, 4'(dreq), 4'(syn), 4'(ann)};
         atss_pkg::addr_stat: rd_word = {28'h0, ptp_locked, pps_lk, nmea_lk, full_second};
         atss_pkg::addr_dt: rd_word = date_time;
         atss_pkg::addr_us: rd_word = {12'h0, us_stamp};
         atss_pkg::addr_offs: rd_word = offs_abs;
         default: rd_word = 32'h0000_0000;
      endcase
      rd_ok = (s_axi_araddr <= atss_pkg::addr_offs) && (s_axi_araddr[1:0] == 2'b00);
      wr_ok = (aw_addr <= atss_pkg::addr_ptp1) && (aw_addr[1:0] == 2'b00);
      next_aw_full = aw_full;
      next_w_full = w_full;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = wr_word;
      end
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_ok ? atss_pkg::resp_okay : atss_pkg::resp_slverr;
      end
      next_src = src;
      next_req_pps = req_pps;
      next_nmode = nmode;
      next_prof = prof;
      next_tr = tr;
      next_port = gnss_port;
      next_limit = limit;
      next_domain = domain;
      next_ann = ann;
      next_syn = syn;
      next_dreq = dreq;
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_ok ? atss_pkg::resp_okay : atss_pkg::resp_slverr;
         case (aw_addr)
            atss_pkg::addr_ctrl: begin
               next_src = atss_pkg::atss_src_t'(w_data[0]);
               next_req_pps = w_data[1];
               next_nmode = atss_pkg::atss_nmea_t'(w_data[2]);
               if (w_data[4:3] <= 2'(atss_pkg::atss_prof_auto)) begin
                  next_prof = atss_pkg::atss_prof_t'(w_data[4:3]);
               end
               next_tr = atss_pkg::atss_tr_t'(w_data[5]);
               // udp only under 1588v2, otherwise forced to layer 2
               if (next_prof != atss_pkg::atss_prof_1588) begin
                  next_tr = atss_pkg::atss_tr_l2;
               end
            end
            atss_pkg::addr_port: next_port = w_data[15:0];
            atss_pkg::addr_ptp0: begin
               if (w_data[6:0] >= atss_pkg::limit_min && w_data[6:0] <= atss_pkg::limit_max) begin
                  next_limit = w_data[6:0];
               end
               next_domain = w_data[22:16] & atss_pkg::domain_max;
            end
            atss_pkg::addr_ptp1: begin
               // 2**n second periods, held as signed exponents
               next_ann = clampi(signed'(w_data[3:0]), atss_pkg::ann_min, atss_pkg::int_max);
               next_syn = clampi(signed'(w_data[7:4]), atss_pkg::sync_min, atss_pkg::int_max);
               next_dreq = clampi(signed'(w_data[11:8]), atss_pkg::sync_min, atss_pkg::int_max);
            end
            default: next_src = src;
         endcase
      end
      // time source and update decisions
      next_offs_abs = offs_abs;
      next_ptp_locked = ptp_locked;
      if (ptp_offset_valid) begin
         next_offs_abs = ptp_offset_ns[31] ? 32'(-ptp_offset_ns) : ptp_offset_ns;
         next_ptp_locked = (next_offs_abs <= lim_ns);
      end
      if (src != atss_pkg::atss_src_ptp) begin
         next_ptp_locked = 1'b0;
      end
      next_dt = date_time;
      align = 1'b0;
      int_tick = (tick_cnt == atss_pkg::int_tick_cycles - 27'h1);
      next_tick_cnt = int_tick ? 27'h0 : tick_cnt + 27'h1;
      full_second = 1'b0;
      if (src == atss_pkg::atss_src_gnss) begin
         if (nmea_lk && nmea_valid && (pps_lk || !req_pps)) begin
            next_dt = nmea_seconds;
         end
         if (pps_lk && pps_rise) begin
            align = 1'b1;
         end
         if (nmea_lk && pps_lk) begin
            full_second = pps_rise;
         end
      end else if (ptp_locked) begin
         full_second = ptp_second;
         align = ptp_second;
      end
      if (!full_second && !(src == atss_pkg::atss_src_gnss && nmea_lk && pps_lk)
            && !(src == atss_pkg::atss_src_ptp && ptp_locked)) begin
         full_second = int_tick;
      end
      // seconds count on from the local microsecond field
      if (next_dt == date_time && us_wrap) begin
         next_dt = date_time + 32'h0000_0001;
      end
      gnss_pkt_en = (src == atss_pkg::atss_src_gnss);
      if (!aresetn) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_aw_addr = 12'h000;
         next_w_data = 32'h0000_0000;
         next_bvalid = 1'b0;
         next_bresp = atss_pkg::resp_okay;
         next_rvalid = 1'b0;
         next_rdata = 32'h0000_0000;
         next_rresp = atss_pkg::resp_okay;
         next_src = atss_pkg::atss_src_gnss;
         next_req_pps = 1'b1;
         next_nmode = atss_pkg::atss_nmea_rmc;
         next_prof = atss_pkg::atss_prof_1588;
         next_tr = atss_pkg::atss_tr_udp;
         next_port = atss_pkg::port_reset;
         next_limit = atss_pkg::limit_reset;
         next_domain = 7'h00;
         next_ann = atss_pkg::ann_reset;
         next_syn = atss_pkg::sync_reset;
         next_dreq = atss_pkg::dreq_reset;
         next_dt = 32'h0000_0000;
         next_offs_abs = 32'h0000_0000;
         next_ptp_locked = 1'b0;
         next_tick_cnt = 27'h0;
      end
   end

   always_ff @(posedge aclk) begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      src <= next_src;
      req_pps <= next_req_pps;
      nmode <= next_nmode;
      prof <= next_prof;
      tr <= next_tr;
      gnss_port <= next_port;
      limit <= next_limit;
      domain <= next_domain;
      ann <= next_ann;
      syn <= next_syn;
      dreq <= next_dreq;
      date_time <= next_dt;
      offs_abs <= next_offs_abs;
      ptp_locked <= next_ptp_locked;
      tick_cnt <= next_tick_cnt;
   end
endmodule // atss_time_core

/* File: tb/atss_partner.sv */
// receiver and timing servo model driving the time core inputs
module atss_partner (
   input wire logic aclk,
   output logic pps = 1'b0,
   output logic nl = 1'b0,
   output logic pl = 1'b0,
   output logic nv = 1'b0,
   output logic [31:0] ns = 32'h0000_0000,
   output logic ov = 1'b0,
   output logic [31:0] on = 32'h0000_0000,
   output logic ps = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // lock levels, then time for the core's synchronisers
   task automatic lock(input logic n, input logic p);
      @(posedge aclk);
      nl <= n;
      pl <= p;
      repeat (8) @(posedge aclk);
   endtask
   task automatic sentence(input logic [31:0] s);
      @(posedge aclk);
      nv <= 1'b1;
      ns <= s;
      @(posedge aclk);
      nv <= 1'b0;
      ns <= ~s; // stale after the pulse
      repeat (4) @(posedge aclk);
   endtask
   task automatic pulse_pps();
      @(posedge aclk);
      pps <= 1'b1;
      repeat (10) @(posedge aclk);
      pps <= 1'b0;
   endtask
   task automatic offset(input logic [31:0] o);
      @(posedge aclk);
      ov <= 1'b1;
      on <= o;
      ps <= 1'b1;
      @(posedge aclk);
      ov <= 1'b0;
      on <= ~o;
      ps <= 1'b0;
   endtask
endmodule // atss_partner

/* File: tb/atss_chk.sv */
// concurrent checks on the time core ports
module atss_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic pps_in,
   input wire logic nmea_lock_in,
   input wire logic pps_lock_in,
   input wire logic nmea_valid,
   input wire logic [31:0] nmea_seconds,
   input wire logic ptp_offset_valid,
   input wire logic [31:0] ptp_offset_ns,
   input wire logic [31:0] date_time,
   input wire logic [19:0] us_stamp,
   input wire logic full_second,
   input wire logic ptp_locked,
   input wire logic gnss_pkt_en,
   input wire logic [15:0] gnss_port
);
   logic [31:0] secs_q, next_secs, mag;
   logic src_q, next_src, ctrl_wr;
   assign ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == atss_pkg::addr_ctrl;
   assign mag = ptp_offset_ns[31] ? -ptp_offset_ns : ptp_offset_ns;
   always_comb begin
      next_secs = nmea_valid ? nmea_seconds : secs_q;
      next_src = ctrl_wr ? s_axi_wdata[0] : src_q;
      if (!aresetn) begin
         next_secs = 32'h0000_0000;
         next_src = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      secs_q <= next_secs;
      src_q <= next_src;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_locks_held;
      nmea_lock_in && pps_lock_in && $past(nmea_lock_in, 4) && $past(pps_lock_in, 4);
   endsequence
   sequence s_pps_locked_rise;
      $rose(pps_in) && pps_lock_in && $past(pps_lock_in, 4) && gnss_pkt_en;
   endsequence
   a_reset_values: assert property ($rose(aresetn) |-> gnss_port == atss_pkg::port_reset
      && gnss_pkt_en && !ptp_locked && date_time == 32'h0000_0000) else $error("bad reset");
   a_src_pkt: assert property (ctrl_wr |-> ##[1:3] gnss_pkt_en == !src_q)
      else $error("packet enable not following source");
   a_lock_within: assert property (src_q && ptp_offset_valid && mag <= 32'h0000_03E8
      |-> ##[1:2] ptp_locked) else $error("small offset not locked");
   a_lock_outside: assert property (ptp_offset_valid && mag > 32'h0001_86A0
      |-> ##[1:2] !ptp_locked) else $error("large offset locked");
   a_lock_cause: assert property (ptp_locked != $past(ptp_locked)
      |-> $past(ptp_offset_valid) || $past(ptp_offset_valid, 2)) else $error("lock moved alone");
   a_date_load: assert property (s_locks_held ##0 nmea_valid
      |-> ##[1:3] date_time == secs_q) else $error("date not loaded");
   a_date_hold: assert property (nmea_valid && !nmea_lock_in && !$past(nmea_lock_in, 4)
      |=> $stable(date_time) [*3]) else $error("date changed while unlocked");
   a_pps_second: assert property (s_locks_held ##0 $rose(pps_in) && gnss_pkt_en
      |-> ##[1:4] full_second) else $error("no full second at pps");
   a_pps_align: assert property (s_pps_locked_rise |-> ##[2:5] us_stamp <= 20'h0_0001)
      else $error("microseconds not aligned");
   a_us_range: assert property (us_stamp <= atss_pkg::us_max)
      else $error("microseconds out of range");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
endmodule // atss_chk

bind atss_time_core atss_chk u_atss_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .pps_in(pps_in), .nmea_lock_in(nmea_lock_in), .pps_lock_in(pps_lock_in),
   .nmea_valid(nmea_valid), .nmea_seconds(nmea_seconds), .ptp_offset_valid(ptp_offset_valid),
   .ptp_offset_ns(ptp_offset_ns), .date_time(date_time), .us_stamp(us_stamp),
   .full_second(full_second), .ptp_locked(ptp_locked), .gnss_pkt_en(gnss_pkt_en),
   .gnss_port(gnss_port));

/* File: tb/testbench.sv */
// self-checking bench for the absolute time core
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd, date_time, ns, on;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, full_second, ptp_locked, gnss_pkt_en;
   logic pps, nl, pl, nv, ov, ps;
   logic [1:0] bresp, rresp, rs;
   logic [19:0] us_stamp;
   logic [15:0] gnss_port;
   int fail_count = 0, tests_run = 0, exp_date;
   always #5 aclk = ~aclk;
   atss_partner u_atss_partner (.aclk(aclk), .pps(pps), .nl(nl), .pl(pl), .nv(nv), .ns(ns),
      .ov(ov), .on(on), .ps(ps));
   atss_time_core u_atss_time_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pps_in(pps),
      .nmea_lock_in(nl), .pps_lock_in(pl), .nmea_valid(nv), .nmea_seconds(ns),
      .ptp_offset_valid(ov), .ptp_offset_ns(on), .ptp_second(ps), .date_time(date_time),
      .us_stamp(us_stamp), .full_second(full_second), .ptp_locked(ptp_locked),
      .gnss_pkt_en(gnss_pkt_en), .gnss_port(gnss_port));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one register access; handshakes and answers taken at the rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tq, tr;
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      tr = 1'b0;
      while (!tr && n < 100) begin
         @(posedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tq = arvalid && arready;
         tr = w ? (bvalid && bready) : (rvalid && rready);
         if (tr) begin
            rs = w ? bresp : rresp;
            rd = rdata;
            bready <= 1'b0;
            rready <= 1'b0;
         end
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tq) arvalid <= 1'b0;
         n++;
      end
      if (!tr) fail_count++;
   endtask
   logic [11:0] ra [4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
   logic [31:0] rv [4] = '{32'h0000_0002, 32'h0000_277E, 32'h0000_0001, 32'h0000_0011};
   logic [11:0] wa [8] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h00C, 12'h008, 12'h008,
      12'h004};
   logic [31:0] wd [8] = '{32'h0000_000E, 32'h0000_000A, 32'h0000_0012, 32'h0000_0022,
      32'h0000_078C, 32'h007F_0000, 32'h0000_0064, 32'h0000_1234};
   logic [31:0] we [8] = '{32'h0000_002E, 32'h0000_002A, 32'h0000_0032, 32'h0000_0022,
      32'h0000_039E, 32'h007F_0001, 32'h0000_0064, 32'h0000_1234};
   int lims [4] = '{100, 100, 1, 1};
   int offs [4] = '{100000, -100001, 1000, -1001};
   logic [3:0] cs [4] = '{4'b1010, 4'b1001, 4'b0100, 4'b0000};
   initial begin
      exp_date = $urandom(83);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         xfer(0, ra[i], 0);
         chk(rd, rv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         xfer(1, wa[i], wd[i]);
         chk(rs, 2'b00);
         xfer(0, wa[i], 0);
         chk(rd, we[i]);
      end
      chk(gnss_port, 32'h0000_1234);
      xfer(1, 12'h000, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         xfer(1, 12'h008, lims[i]);
         u_atss_partner.offset(offs[i]);
         repeat (3) @(posedge aclk);
         chk(ptp_locked, offs[i] <= lims[i] * 1000 && offs[i] >= -lims[i] * 1000);
      end
      xfer(1, 12'h010, 0);
      chk(rs, 2'b10);
      xfer(0, 12'h024, 0);
      chk(rd, 32'h0000_0000);
      chk(rs, 2'b10);
      xfer(1, 12'h000, 32'h0000_0002);
      u_atss_partner.lock(1'b1, 1'b1);
      exp_date = $urandom();
      u_atss_partner.sentence(exp_date);
      chk(date_time, exp_date);
      u_atss_partner.pulse_pps();
      chk(us_stamp, 20'h0_0000);
      for (int i = 0; i < 4; i++) begin
         xfer(1, 12'h000, {30'h0, cs[i][1], 1'b0});
         u_atss_partner.lock(cs[i][3], cs[i][2]);
         rd = $urandom();
         if (cs[i][0]) exp_date = rd;
         u_atss_partner.sentence(rd);
         chk(date_time, exp_date);
         repeat (300) @(posedge aclk);
         u_atss_partner.pulse_pps();
         chk(us_stamp == 20'h0_0000, cs[i][2]);
      end
      xfer(1, 12'h000, 32'h0000_0003);
      repeat (3) @(posedge aclk);
      chk(gnss_pkt_en, 0);
      results();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      results();
   end
endmodule // testbench
